// [pzd_pkg.sv]
/*
 * constants for the zero-delay control and pll status register slice.
 * assumes the serial control port core presents decoded 10-bit register addresses.
 */
`default_nettype none
package pzd_pkg;
	// ***************
	// address map
	// ***************
	localparam int unsigned ADDR_W            = 10;
	localparam logic [9:0]  ZERO_DELAY_CTRL_A = 10'h01E;
	localparam logic [9:0]  PLL_STATUS_A      = 10'h01F;

	// ***************
	// control fields
	// ***************
	localparam int unsigned ZD_ENABLE_BIT = 1;
	localparam int unsigned ZD_EXT_BIT    = 2;
	localparam int unsigned ZD_FBSEL_LSB  = 3;
	localparam int unsigned ZD_FBSEL_W    = 2;
	localparam logic [7:0]  ZD_CTRL_RESET = 8'h00;
	localparam logic [7:0]  ZD_CTRL_MASK  = 8'h1E;

	// ***************
	// status fields
	// ***************
	localparam int unsigned ST_LOCK_BIT     = 0;
	localparam int unsigned ST_PRI_FREQ_BIT = 1;
	localparam int unsigned ST_SEC_FREQ_BIT = 2;
	localparam int unsigned ST_VCO_FREQ_BIT = 3;
	localparam int unsigned ST_SEC_SEL_BIT  = 4;
	localparam int unsigned ST_HOLDOVER_BIT = 5;
	localparam int unsigned ST_VCO_CAL_BIT  = 6;
	localparam int unsigned ST_W            = 7;
	localparam logic [6:0]  ST_RESET        = 7'h00;
	localparam logic [7:0]  RD_DEFAULT      = 8'h00;
endpackage
`default_nettype wire

// [pzd_status_regs.sv]
/*
 * zero-delay control register and read-only pll status register.
 * the control byte gates zero-delay operation, picks internal or external mode
 * and carries the feedback divider select out to the pll core.
 * the status byte reports calibration, holdover, reference choice, the three
 * frequency-monitor comparisons and digital lock, each captured through three
 * flops before it may be read.
 * assumes a serial control port core issues single-cycle read and write strobes
 * on core_clk, with the address valid in the same cycle.
 * assumes status levels arrive unsynchronised from the pll core and hold for
 * several cycles at a time; a level shorter than two cycles may be missed.
 * assumes the pll core reads the control outputs as plain levels.
 */
`timescale 1ns/1ps
`default_nettype none

module pzd_status_regs (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,

	// register access from the serial port core
	input  wire logic [9:0]  regAddr,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regRdEn,
	output var  logic [7:0]  regRdData,
	output var  logic        regRdValid,

	// status levels from the pll core
	input  wire logic        vcoCalDone,
	input  wire logic        holdoverActive,
	input  wire logic        secondaryRefSelected,
	input  wire logic        vcoFreqAboveThresh,
	input  wire logic        secondaryRefAboveThresh,
	input  wire logic        primaryRefAboveThresh,
	input  wire logic        digitalLocked,

	// zero-delay controls to the pll core
	output var  logic        zeroDelayEnable,
	output var  logic        extZeroDelayMode,
	output var  logic [1:0]  zeroDelayFbSel
);

	// ***************
	// state
	// ***************
	typedef struct packed {
		// control byte as stored; unused positions stay zero
		logic [7:0] ctrl;
		// three capture stages for the asynchronous status levels
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [6:0] sync3;
		// committed status, moves only when stages two and three agree
		logic [6:0] status;
		// read port
		logic [7:0] rdData;
		logic       rdValid;
		// control outputs, registered so every pin leaves a flop
		logic       zdEn;
		logic       zdExt;
		logic [1:0] fbSel;
	} pzd_state_s;

	pzd_state_s state_q;
	pzd_state_s state_d;

	// status levels at their byte positions, before capture
	logic [6:0] rawStatus;

	// ***************
	// decode helpers
	// ***************
	// write and read share one address match so the two decodes cannot drift apart
	function automatic logic hitsCtrl(
		input logic [9:0] addr
	);
		hitsCtrl = (addr == pzd_pkg::ZERO_DELAY_CTRL_A);
	endfunction

	function automatic logic hitsStatus(
		input logic [9:0] addr
	);
		hitsStatus = (addr == pzd_pkg::PLL_STATUS_A);
	endfunction

	// only the defined fields are kept, so a read never shows junk in unused bits
	function automatic logic [7:0] storeCtrl(
		input logic [7:0] data
	);
		storeCtrl = 8'h00;
		storeCtrl[pzd_pkg::ZD_ENABLE_BIT] = data[pzd_pkg::ZD_ENABLE_BIT];
		storeCtrl[pzd_pkg::ZD_EXT_BIT] = data[pzd_pkg::ZD_EXT_BIT];
		storeCtrl[pzd_pkg::ZD_FBSEL_LSB +: pzd_pkg::ZD_FBSEL_W] = data[pzd_pkg::ZD_FBSEL_LSB +: pzd_pkg::ZD_FBSEL_W];
	endfunction

	// a bit still settling between the late stages keeps its committed value
	function automatic logic [6:0] commitStatus(
		input logic [6:0] held,
		input logic [6:0] late,
		input logic [6:0] last
	);
		commitStatus = held;
		for (int i = 0; i < int'(pzd_pkg::ST_W); i++) begin
			if (late[i] == last[i]) begin
				commitStatus[i] = last[i];
			end
		end
	endfunction

	// ***************
	// next state
	// ***************
	always_comb begin
		state_d = state_q;
		state_d.rdValid = 1'b0;
		rawStatus = 7'h00;

		// ***************
		// status capture
		// ***************
		// calibration finished
		rawStatus[pzd_pkg::ST_VCO_CAL_BIT] = vcoCalDone;
		rawStatus[pzd_pkg::ST_HOLDOVER_BIT] = holdoverActive;
		rawStatus[pzd_pkg::ST_SEC_SEL_BIT] = secondaryRefSelected;
		rawStatus[pzd_pkg::ST_VCO_FREQ_BIT] = vcoFreqAboveThresh;
		rawStatus[pzd_pkg::ST_SEC_FREQ_BIT] = secondaryRefAboveThresh;
		rawStatus[pzd_pkg::ST_PRI_FREQ_BIT] = primaryRefAboveThresh;
		rawStatus[pzd_pkg::ST_LOCK_BIT] = digitalLocked;

		// first stage feeds only the second; a lone one-cycle glitch never commits
		state_d.sync1 = rawStatus;
		state_d.sync2 = state_q.sync1;
		state_d.sync3 = state_q.sync2;
		state_d.status = commitStatus(state_q.status, state_q.sync2, state_q.sync3);

		// ***************
		// control write
		// ***************
		// unused bits never stored
		if (regWrEn && hitsCtrl(regAddr)) begin
			state_d.ctrl = storeCtrl(regWrData);
		end

		// ***************
		// control outputs
		// ***************
		// zero delay gate
		state_d.zdEn = state_d.ctrl[pzd_pkg::ZD_ENABLE_BIT];
		// external mode only counts while enabled
		state_d.zdExt = state_d.ctrl[pzd_pkg::ZD_ENABLE_BIT] & state_d.ctrl[pzd_pkg::ZD_EXT_BIT];
		// divider select reaches the pll core unchanged
		state_d.fbSel = state_d.ctrl[pzd_pkg::ZD_FBSEL_LSB +: pzd_pkg::ZD_FBSEL_W];

		// ***************
		// read port
		// ***************
		// reads see the byte before any same-cycle write lands
		if (regRdEn) begin
			state_d.rdValid = 1'b1;
			if (hitsCtrl(regAddr)) begin
				state_d.rdData = state_q.ctrl;
			end else if (hitsStatus(regAddr)) begin
				state_d.rdData = {1'b0, state_q.status};
			end else begin
				// unmapped addresses read zero
				state_d.rdData = pzd_pkg::RD_DEFAULT;
			end
		end
	end

	// ***************
	// registers
	// ***************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q.ctrl    <= pzd_pkg::ZD_CTRL_RESET;
			state_q.sync1   <= pzd_pkg::ST_RESET;
			state_q.sync2   <= pzd_pkg::ST_RESET;
			state_q.sync3   <= pzd_pkg::ST_RESET;
			state_q.status  <= pzd_pkg::ST_RESET;
			state_q.rdData  <= pzd_pkg::RD_DEFAULT;
			state_q.rdValid <= 1'b0;
			// control outputs restart from the control byte's own reset value
			state_q.zdEn    <= pzd_pkg::ZD_CTRL_RESET[pzd_pkg::ZD_ENABLE_BIT];
			state_q.zdExt   <= pzd_pkg::ZD_CTRL_RESET[pzd_pkg::ZD_ENABLE_BIT] & pzd_pkg::ZD_CTRL_RESET[pzd_pkg::ZD_EXT_BIT];
			state_q.fbSel   <= pzd_pkg::ZD_CTRL_RESET[pzd_pkg::ZD_FBSEL_LSB +: pzd_pkg::ZD_FBSEL_W];
		end else begin
			state_q <= state_d;
		end
	end

	// ***************
	// outputs
	// ***************
	// every output is a flop of the state struct
	assign regRdData        = state_q.rdData;
	assign regRdValid       = state_q.rdValid;
	assign zeroDelayEnable  = state_q.zdEn;
	assign extZeroDelayMode = state_q.zdExt;
	assign zeroDelayFbSel   = state_q.fbSel;

endmodule // pzd_status_regs
`default_nettype wire

// [pzd_status_regs_properties.sv]
/* port checker for pzd_status_regs.
   assumes one core_clk domain and one-cycle strobes. */
`timescale 1ns/1ps
`default_nettype none
module pzd_status_props (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// register port
	input wire logic [9:0] regAddr,
	input wire logic       regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic       regRdValid,
	// watched levels
	input wire logic       digitalLocked,
	input wire logic       zeroDelayEnable,
	input wire logic       extZeroDelayMode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire cw = regWrEn && regAddr == 10'h01E;
	wire cr = regRdEn && regAddr == 10'h01E;
	wire sr = regRdEn && regAddr == 10'h01F;
	sequence s_steady; $stable(digitalLocked)[*8]; endsequence
	a_zd_en: assert property (cw |=> zeroDelayEnable == $past(regWrData[1])) else $error("enable");
	a_ext_mode: assert property (cw |=> extZeroDelayMode == &$past(regWrData[2:1])) else $error("mode");
	a_ext_gate: assert property (!zeroDelayEnable |-> !extZeroDelayMode) else $error("gate");
	a_ctl_unused: assert property (cr |=> regRdValid && !regRdData[7:5] && !regRdData[0]) else $error("c");
	a_ctl_back: assert property (cr |=> regRdData[1] == $past(zeroDelayEnable)) else $error("back");
	a_st_unused: assert property (sr |=> regRdValid && !regRdData[7]) else $error("bit7");
	a_lock_read: assert property (s_steady ##0 sr |=> regRdData[0] == $past(digitalLocked)) else $error("lk");
	a_valid_src: assert property (regRdValid |-> $past(regRdEn)) else $error("valid");
endmodule // pzd_status_props
bind pzd_status_regs pzd_status_props u_props (.*);
`default_nettype wire

// [pzd_pll_model.sv]
/* pll core stand-in: status levels.
   assumes step is a one-cycle pulse from the bench. */
`timescale 1ns/1ps
`default_nettype none
module pzd_pll_model (
	input wire logic       core_clk,
	input wire logic       step,
	output var logic [6:0] st
);
	int seed = 31354;
	initial st = 7'h00;
	always @(posedge core_clk) if (step) st <= 7'($random(seed));
endmodule // pzd_pll_model
`default_nettype wire

// [testbench.sv]
/* bench for pzd_status_regs.
   assumes pzd_pll_model drives the status levels. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       core_clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, step = 0;
	logic [9:0] regAddr = 0;
	logic [7:0] regWrData = 0, regRdData, d;
	logic       regRdValid, zeroDelayEnable, extZeroDelayMode;
	logic [1:0] fbSel;
	logic [6:0] st;
	logic [7:0] expQ[$];
	int         error_cnt = 0, tests_run = 0, seed = 31354;
	always #2.5 core_clk = ~core_clk;
	pzd_pll_model pll (.core_clk, .step, .st);
	pzd_status_regs dut (.core_clk, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid,
		.vcoCalDone(st[6]), .holdoverActive(st[5]), .secondaryRefSelected(st[4]), .vcoFreqAboveThresh(st[3]),
		.secondaryRefAboveThresh(st[2]), .primaryRefAboveThresh(st[1]), .digitalLocked(st[0]),
		.zeroDelayEnable, .extZeroDelayMode, .zeroDelayFbSel(fbSel));
	task chk(input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task acc(input logic wr, input logic [9:0] a, input logic [7:0] v);
		@(posedge core_clk) regAddr <= a;
		regWrData <= v;
		if (wr) regWrEn <= 1;
		else begin
			regRdEn <= 1;
			expQ.push_back(v);
		end
		@(posedge core_clk) regWrEn <= 0;
		regRdEn <= 0;
	endtask
	// oldest note matched to each answer
	always @(negedge core_clk) if (regRdValid === 1'b1) begin
		// an answer with no note pending is itself a mismatch
		if (expQ.size() > 0) chk(regRdData, expQ.pop_front());
		else error_cnt++;
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 0;
		acc(0, 10'h01E, pzd_pkg::ZD_CTRL_RESET);
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			acc(1, 10'h01E, d);
			@(negedge core_clk) chk({fbSel, zeroDelayEnable, extZeroDelayMode}, {d[4:3], d[1], d[1] & d[2]});
			// writes elsewhere must leave control alone
			acc(1, 10'h01F, ~d);
			acc(1, 10'h2A5, ~d);
			acc(0, 10'h01E, d & 8'h1E);
			@(posedge core_clk) step <= 1;
			@(posedge core_clk) step <= 0;
			repeat (10) @(posedge core_clk);
			acc(0, 10'h01F, {1'b0, st});
			acc(0, 10'h155, 8'h00);
		end
		// mid-run reset must bring the control defaults back
		@(posedge core_clk) rst <= 1;
		repeat (2) @(posedge core_clk);
		rst <= 0;
		@(negedge core_clk) chk({fbSel, zeroDelayEnable, extZeroDelayMode}, 8'h00);
		acc(0, 10'h01E, pzd_pkg::ZD_CTRL_RESET);
		for (int i = 0; i < 20 && expQ.size() > 0; i++) @(posedge core_clk);
		if (expQ.size() > 0) error_cnt++;
		results();
	end
endmodule // testbench
`default_nettype wire
